/* File: verilog/pin_mux_pkg.sv */
/*
 * Constants and carrier types for the shared pin function selector.
 * Assumes one 100 MHz clock and an active-low asynchronous reset.
 */
package pin_mux_pkg;

    // Register indexes on the plain register port
    localparam logic [3:0] REG_MODE = 4'h0;
    localparam logic [3:0] REG_FUNC_EN = 4'h1;
    localparam logic [3:0] REG_P3_DATA = 4'h2;
    localparam logic [3:0] REG_P3_DIR = 4'h3;
    localparam logic [3:0] REG_P4_DATA = 4'h4;
    localparam logic [3:0] REG_P4_DIR = 4'h5;
    localparam logic [3:0] REG_P5_DATA = 4'h6;
    localparam logic [3:0] REG_ANALOG_EN = 4'h7;
    localparam logic [3:0] REG_P7_DATA = 4'h8;
    localparam logic [3:0] REG_P7_DIR = 4'h9;
    localparam logic [3:0] REG_P8_DATA = 4'hA;
    localparam logic [3:0] REG_P8_DIR = 4'hB;
    localparam logic [3:0] REG_P9_DATA = 4'hC;
    localparam logic [3:0] REG_P3_IN = 4'hD;
    localparam logic [3:0] REG_P4_IN = 4'hE;
    localparam logic [3:0] REG_P5_IN = 4'hF;

    // Bit positions in the function enable register
    localparam int FE_WRL = 0;
    localparam int FE_WRH = 1;
    localparam int FE_HOLD = 2;
    localparam int FE_READY = 3;
    localparam int FE_BUSCLK = 4;
    localparam int FE_S0_TX = 5;
    localparam int FE_S0_CLK = 6;
    localparam int FE_S1_TX = 7;
    localparam int FE_S1_CLK = 8;
    localparam int FE_PG0 = 9;
    localparam int FE_PG1 = 10;
    localparam int FE_CMP = 11;
    localparam int FE_TWI = 12;

    // Port 3 bit positions
    localparam int P3_ALE = 0;
    localparam int P3_RD = 1;
    localparam int P3_WRL = 2;
    localparam int P3_WRH = 3;
    localparam int P3_HRQ = 4;
    localparam int P3_HAK = 5;
    localparam int P3_RDY = 6;
    localparam int P3_CLK = 7;

    // Reset values
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [7:0] RST_ANALOG = 8'hFF;
    localparam logic [12:0] RST_FUNC = 13'h0000;
    localparam logic [1:0] RST_P9 = 2'h3;

    typedef enum logic [1:0] {
        MODE_SINGLE = 2'b00,
        MODE_BUS8 = 2'b01,
        MODE_BUS16 = 2'b10
    } op_mode_t;

    // Register port request
    typedef struct packed {
        logic [3:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
    } reg_req_t;

    // Signals that the peripherals hand to the pins
    typedef struct packed {
        logic ale;
        logic rd_strobe;
        logic write_strobe_low;
        logic write_strobe_high;
        logic bus_hold_grant;
        logic bus_clk;
        logic serial0_tx_out;
        logic serial0_clock_out;
        logic serial1_tx_out;
        logic serial1_clock_out;
        logic pulse_gen0_out;
        logic pulse_gen1_out;
        logic [7:0] compare_wave_outputs;
        logic sda_out;
        logic scl_out;
    } periph_out_t;

    // Signals that the pins hand back to the peripherals
    typedef struct packed {
        logic bus_hold_request;
        logic bus_ready;
        logic serial0_rx_in;
        logic serial0_clock_in;
        logic serial1_rx_in;
        logic serial1_clock_in;
        logic conversion_trigger_in;
        logic [3:0] ext_irq_inputs;
        logic [3:0] capture_sample_inputs;
        logic [7:0] analog_inputs;
        logic sda_in;
        logic scl_in;
    } periph_in_t;

endpackage : pin_mux_pkg

/* File: verilog/shared_pin_function_select.sv */
/*
 * Shared pin function selector: picks port bit or peripheral function per pin.
 * Assumes synchronous pin inputs and a register master that never waits.
 */
// Strobed register access and the placing of the registers were decided locally.
// Overview of operation
// - P3.0 is a port bit in single-chip mode, address latch enable on bus.
// - P3.1 is a port bit in single-chip mode, read strobe on bus.
// - Low write strobe only with bus on and its output enabled.
// - High write strobe only in 16-bit bus mode with output enabled.
// - Hold request and grant only with bus on and hold enabled.
// - Ready input honoured only with bus on and ready enabled.
// - Bus clock out only with bus on and clock output enabled.
// - Serial 0 transmit pin carries data when enabled, else port bit.
// - Serial 0 clock driven when enabled; pin always sampled as clock.
// - Serial 1 transmit pin carries data when enabled, else port bit.
// - Serial 1 clock pin is port output only while clock output disabled.
// - Pulse channel 0 replaces its port bit while its output is enabled.
// - Pulse channel 1 replaces its port bit while its output is enabled.
// - Input-only functions other than hold request, ready and analog inputs always sample their pins; software disables port output.
// - Analog-shared pins give digital input only for bits selected as port.
// - Compare outputs reach pins only with enable and port output set.
`timescale 1ns/1ps
`default_nettype none

module shared_pin_function_select (
    input wire logic clk,
    input wire logic rstn,
    input wire pin_mux_pkg::reg_req_t req,
    output logic [15:0] rdata,
    input wire pin_mux_pkg::periph_out_t periph_out,
    output pin_mux_pkg::periph_in_t periph_in,
    input wire logic [7:0] p3_in,
    output logic [7:0] p3_out,
    output logic [7:0] p3_oe,
    input wire logic [7:0] p4_in,
    output logic [7:0] p4_out,
    output logic [7:0] p4_oe,
    input wire logic [7:0] p5_in,
    output logic [7:0] p5_out,
    output logic [7:0] p5_oe,
    input wire logic [7:0] analog_inputs,
    input wire logic [7:0] p6_in,
    input wire logic [7:0] p7_in,
    output logic [7:0] p7_out,
    output logic [7:0] p7_oe,
    input wire logic p8_in,
    output logic p8_out,
    output logic p8_oe,
    input wire logic [1:0] p9_in,
    output logic [1:0] p9_out,
    output logic [1:0] p9_oe
);

    pin_mux_pkg::op_mode_t mode_q;
    logic [12:0] func_q;
    logic [7:0] p3_data_q, p3_dir_q, p4_data_q, p4_dir_q, p5_data_q, analog_en_q;
    logic [7:0] p7_data_q, p7_dir_q;
    logic p8_data_q, p8_dir_q;
    logic [1:0] p9_data_q;
    logic [15:0] rdata_d;

    // Port bit or function per bit: function where sel is set
    function automatic logic [7:0] pick8(input logic [7:0] sel, input logic [7:0] fn, input logic [7:0] port);
        pick8 = (sel & fn) | (~sel & port);
    endfunction : pick8

    // Write hit on one register index
    function automatic logic reg_hit(input pin_mux_pkg::reg_req_t r, input logic [3:0] idx);
        reg_hit = r.wr && (r.addr == idx);
    endfunction : reg_hit

    // Function select conditions
    wire bus_on = (mode_q != pin_mux_pkg::MODE_SINGLE);
    wire sel_wrl = bus_on && func_q[pin_mux_pkg::FE_WRL];
    wire sel_wrh = (mode_q == pin_mux_pkg::MODE_BUS16) && func_q[pin_mux_pkg::FE_WRH];
    wire sel_hold = bus_on && func_q[pin_mux_pkg::FE_HOLD];
    wire sel_rdy = bus_on && func_q[pin_mux_pkg::FE_READY];
    wire sel_clk = bus_on && func_q[pin_mux_pkg::FE_BUSCLK];
    wire [7:0] sel_cmp = {8{func_q[pin_mux_pkg::FE_CMP]}} & p7_dir_q;

    // Port 3 selection: bit mask of function-owned pins with value and enable
    wire [7:0] p3_fsel = {sel_clk, sel_rdy, sel_hold, sel_hold, sel_wrh, sel_wrl, bus_on, bus_on};
    wire [7:0] p3_fval = {periph_out.bus_clk, 1'b0, periph_out.bus_hold_grant, 1'b0,
                          periph_out.write_strobe_high, periph_out.write_strobe_low,
                          periph_out.rd_strobe, periph_out.ale};
    wire [7:0] p3_foe = {1'b1, 1'b0, 1'b1, 1'b0, 4'hF};
    wire [7:0] p3_out_d = pick8(p3_fsel, p3_fval, p3_data_q);
    wire [7:0] p3_oe_d = pick8(p3_fsel, p3_foe, p3_dir_q);

    // Port 4 selection: bits 1,2,4,5,6 have output functions
    wire [7:0] p4_fsel = {1'b0, func_q[pin_mux_pkg::FE_PG0], func_q[pin_mux_pkg::FE_S1_CLK],
                          func_q[pin_mux_pkg::FE_S1_TX], 1'b0, func_q[pin_mux_pkg::FE_S0_CLK],
                          func_q[pin_mux_pkg::FE_S0_TX], 1'b0};
    wire [7:0] p4_fval = {1'b0, periph_out.pulse_gen0_out, periph_out.serial1_clock_out,
                          periph_out.serial1_tx_out, 1'b0, periph_out.serial0_clock_out,
                          periph_out.serial0_tx_out, 1'b0};
    wire [7:0] p4_out_d = pick8(p4_fsel, p4_fval, p4_data_q);
    wire [7:0] p4_oe_d = p4_fsel | p4_dir_q;

    // Port 7 compare outputs
    wire [7:0] p7_out_d = pick8(sel_cmp, periph_out.compare_wave_outputs, p7_data_q);
    wire [7:0] p7_oe_d = p7_dir_q;

    // Pulse channel 1 on port 8
    wire p8_out_d = func_q[pin_mux_pkg::FE_PG1] ? periph_out.pulse_gen1_out : p8_data_q;
    wire p8_oe_d = func_q[pin_mux_pkg::FE_PG1] | p8_dir_q;

    // Open-drain: drive low only; two-wire data ANDed with port data
    wire twi_on = func_q[pin_mux_pkg::FE_TWI];
    wire [1:0] p9_lvl = p9_data_q & (twi_on ? {periph_out.scl_out, periph_out.sda_out} : 2'h3);
    wire [7:0] p5_oe_d = ~p5_data_q & ~analog_en_q;

    // Inputs to peripherals; hold request, ready and analog inputs gated, the rest always sampled
    pin_mux_pkg::periph_in_t periph_in_d;
    assign periph_in_d.bus_hold_request = sel_hold & p3_in[pin_mux_pkg::P3_HRQ];
    assign periph_in_d.bus_ready = sel_rdy ? p3_in[pin_mux_pkg::P3_RDY] : 1'b1;
    assign periph_in_d.serial0_rx_in = p4_in[0];
    assign periph_in_d.serial0_clock_in = p4_in[2];
    assign periph_in_d.serial1_rx_in = p4_in[3];
    assign periph_in_d.serial1_clock_in = p4_in[5];
    assign periph_in_d.conversion_trigger_in = p4_in[7];
    assign periph_in_d.ext_irq_inputs = p6_in[3:0];
    assign periph_in_d.capture_sample_inputs = p6_in[7:4];
    assign periph_in_d.analog_inputs = analog_inputs & analog_en_q;
    assign periph_in_d.sda_in = p9_in[0];
    assign periph_in_d.scl_in = p9_in[1];

    // Register write decode, one strobe per writable index
    wire wr_mode = reg_hit(req, pin_mux_pkg::REG_MODE);
    wire wr_func = reg_hit(req, pin_mux_pkg::REG_FUNC_EN);
    wire wr_p3_data = reg_hit(req, pin_mux_pkg::REG_P3_DATA);
    wire wr_p3_dir = reg_hit(req, pin_mux_pkg::REG_P3_DIR);
    wire wr_p4_data = reg_hit(req, pin_mux_pkg::REG_P4_DATA);
    wire wr_p4_dir = reg_hit(req, pin_mux_pkg::REG_P4_DIR);
    wire wr_p5_data = reg_hit(req, pin_mux_pkg::REG_P5_DATA);
    wire wr_analog_en = reg_hit(req, pin_mux_pkg::REG_ANALOG_EN);
    wire wr_p7_data = reg_hit(req, pin_mux_pkg::REG_P7_DATA);
    wire wr_p7_dir = reg_hit(req, pin_mux_pkg::REG_P7_DIR);
    wire wr_p8_data = reg_hit(req, pin_mux_pkg::REG_P8_DATA);
    wire wr_p8_dir = reg_hit(req, pin_mux_pkg::REG_P8_DIR);
    wire wr_p9_data = reg_hit(req, pin_mux_pkg::REG_P9_DATA);

    // Read mux; port 5 digital input masked for analog bits
    always_comb begin
        unique case (req.addr)
            pin_mux_pkg::REG_MODE: rdata_d = {14'h0000, mode_q};
            pin_mux_pkg::REG_FUNC_EN: rdata_d = {3'h0, func_q};
            pin_mux_pkg::REG_P3_DATA: rdata_d = {8'h00, p3_data_q};
            pin_mux_pkg::REG_P3_DIR: rdata_d = {8'h00, p3_dir_q};
            pin_mux_pkg::REG_P4_DATA: rdata_d = {8'h00, p4_data_q};
            pin_mux_pkg::REG_P4_DIR: rdata_d = {8'h00, p4_dir_q};
            pin_mux_pkg::REG_P5_DATA: rdata_d = {8'h00, p5_data_q};
            pin_mux_pkg::REG_ANALOG_EN: rdata_d = {8'h00, analog_en_q};
            pin_mux_pkg::REG_P7_DATA: rdata_d = {8'h00, p7_data_q};
            pin_mux_pkg::REG_P7_DIR: rdata_d = {8'h00, p7_dir_q};
            pin_mux_pkg::REG_P8_DATA: rdata_d = {15'h0000, p8_data_q};
            pin_mux_pkg::REG_P8_DIR: rdata_d = {15'h0000, p8_dir_q};
            pin_mux_pkg::REG_P9_DATA: rdata_d = {14'h0000, p9_data_q};
            pin_mux_pkg::REG_P3_IN: rdata_d = {p7_in, p3_in};
            pin_mux_pkg::REG_P4_IN: rdata_d = {p6_in, p4_in};
            pin_mux_pkg::REG_P5_IN: rdata_d = {7'h00, p8_in, p5_in & ~analog_en_q};
        endcase
    end

    // Mode code 3 is reserved: a write of it leaves the mode alone
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            mode_q <= pin_mux_pkg::MODE_SINGLE;
        end else if (wr_mode && (req.wdata[1:0] != 2'h3)) begin
            mode_q <= pin_mux_pkg::op_mode_t'(req.wdata[1:0]);
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            func_q <= pin_mux_pkg::RST_FUNC;
        end else if (wr_func) begin
            func_q <= req.wdata[12:0];
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            p3_data_q <= pin_mux_pkg::RST_BYTE;
        end else if (wr_p3_data) begin
            p3_data_q <= req.wdata[7:0];
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            p3_dir_q <= pin_mux_pkg::RST_BYTE;
        end else if (wr_p3_dir) begin
            p3_dir_q <= req.wdata[7:0];
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            p4_data_q <= pin_mux_pkg::RST_BYTE;
        end else if (wr_p4_data) begin
            p4_data_q <= req.wdata[7:0];
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            p4_dir_q <= pin_mux_pkg::RST_BYTE;
        end else if (wr_p4_dir) begin
            p4_dir_q <= req.wdata[7:0];
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            p5_data_q <= pin_mux_pkg::RST_BYTE;
        end else if (wr_p5_data) begin
            p5_data_q <= req.wdata[7:0];
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            analog_en_q <= pin_mux_pkg::RST_ANALOG;
        end else if (wr_analog_en) begin
            analog_en_q <= req.wdata[7:0];
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            p7_data_q <= pin_mux_pkg::RST_BYTE;
        end else if (wr_p7_data) begin
            p7_data_q <= req.wdata[7:0];
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            p7_dir_q <= pin_mux_pkg::RST_BYTE;
        end else if (wr_p7_dir) begin
            p7_dir_q <= req.wdata[7:0];
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            p8_data_q <= 1'b0;
        end else if (wr_p8_data) begin
            p8_data_q <= req.wdata[0];
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            p8_dir_q <= 1'b0;
        end else if (wr_p8_dir) begin
            p8_dir_q <= req.wdata[0];
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            p9_data_q <= pin_mux_pkg::RST_P9;
        end else if (wr_p9_data) begin
            p9_data_q <= req.wdata[1:0];
        end
    end

    // Read data stands only in the cycle after a read
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rdata <= 16'h0000;
        end else begin
            rdata <= req.rd ? rdata_d : 16'h0000;
        end
    end

    // Ready idles high so a disabled wait input never stalls the bus
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            periph_in <= '{bus_ready: 1'b1, default: '0};
        end else begin
            periph_in <= periph_in_d;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            p3_out <= pin_mux_pkg::RST_BYTE;
            p3_oe <= pin_mux_pkg::RST_BYTE;
        end else begin
            p3_out <= p3_out_d;
            p3_oe <= p3_oe_d;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            p4_out <= pin_mux_pkg::RST_BYTE;
            p4_oe <= pin_mux_pkg::RST_BYTE;
        end else begin
            p4_out <= p4_out_d;
            p4_oe <= p4_oe_d;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            p5_out <= pin_mux_pkg::RST_BYTE;
            p5_oe <= pin_mux_pkg::RST_BYTE;
        end else begin
            p5_out <= 8'h00;
            p5_oe <= p5_oe_d;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            p7_out <= pin_mux_pkg::RST_BYTE;
            p7_oe <= pin_mux_pkg::RST_BYTE;
        end else begin
            p7_out <= p7_out_d;
            p7_oe <= p7_oe_d;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            p8_out <= 1'b0;
            p8_oe <= 1'b0;
        end else begin
            p8_out <= p8_out_d;
            p8_oe <= p8_oe_d;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            p9_out <= 2'h0;
            p9_oe <= 2'h0;
        end else begin
            p9_out <= 2'h0;
            p9_oe <= ~p9_lvl;
        end
    end

endmodule : shared_pin_function_select

`default_nettype wire

/* File: dv/pin_mux_checker.sv */
/* Port checker for the shared pin selector, bound to the top module.
   Assumes registers written through the plain port only. */
`timescale 1ns/1ps
`default_nettype none
module pin_mux_checker (
    input wire logic clk,
    input wire logic rstn,
    input wire pin_mux_pkg::reg_req_t req,
    input wire pin_mux_pkg::periph_out_t periph_out,
    input wire pin_mux_pkg::periph_in_t periph_in,
    input wire logic [7:0] p3_out,
    input wire logic [7:0] p3_oe,
    input wire logic [7:0] p4_in,
    input wire logic [7:0] p4_out,
    input wire logic [7:0] p4_oe,
    input wire logic p8_out,
    input wire logic p8_oe
);
    logic [1:0] mode_q;
    logic [12:0] fe_q;
    logic [7:0] d3_q;
    // Shadow of the selection registers
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            mode_q <= 2'h0;
            fe_q <= 13'h0000;
            d3_q <= 8'h00;
        end else if (req.wr) begin
            if (req.addr == pin_mux_pkg::REG_MODE && req.wdata[1:0] != 2'h3) mode_q <= req.wdata[1:0];
            if (req.addr == pin_mux_pkg::REG_FUNC_EN) fe_q <= req.wdata[12:0];
            if (req.addr == pin_mux_pkg::REG_P3_DATA) d3_q <= req.wdata[7:0];
        end
    end
    wire logic bus_on = mode_q != 2'h0;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    property p_ale; bus_on |=> p3_oe[0] && p3_out[0] == $past(periph_out.ale); endproperty
    a_ale: assert property (p_ale) else $error("latch enable pin wrong");
    property p_rd; bus_on |=> p3_oe[1] && p3_out[1] == $past(periph_out.rd_strobe); endproperty
    a_rd: assert property (p_rd) else $error("read strobe pin wrong");
    property p_wrl; bus_on && fe_q[0] |=> p3_oe[2] && p3_out[2] == $past(periph_out.write_strobe_low); endproperty
    a_wrl: assert property (p_wrl) else $error("low write strobe pin wrong");
    property p_wrh; !(mode_q == 2'h2 && fe_q[1]) |=> !p3_oe[3] || p3_out[3] == $past(d3_q[3]); endproperty
    a_wrh: assert property (p_wrh) else $error("high write strobe pin not port");
    property p_hold; bus_on && fe_q[2] |=> !p3_oe[4] && p3_oe[5] && p3_out[5] == $past(periph_out.bus_hold_grant);
    endproperty
    a_hold: assert property (p_hold) else $error("hold pins wrong");
    property p_rdy; !(bus_on && fe_q[3]) |=> periph_in.bus_ready; endproperty
    a_rdy: assert property (p_rdy) else $error("ready not forced");
    property p_clk; bus_on && fe_q[4] |=> p3_oe[7] && p3_out[7] == $past(periph_out.bus_clk); endproperty
    a_clk: assert property (p_clk) else $error("bus clock pin wrong");
    property p_s0tx; fe_q[5] |=> p4_oe[1] && p4_out[1] == $past(periph_out.serial0_tx_out); endproperty
    a_s0tx: assert property (p_s0tx) else $error("serial 0 transmit pin wrong");
    property p_pg1; fe_q[10] |=> p8_oe && p8_out == $past(periph_out.pulse_gen1_out); endproperty
    a_pg1: assert property (p_pg1) else $error("pulse 1 pin wrong");
    property p_rx; 1'b1 |=> periph_in.serial0_rx_in == $past(p4_in[0]); endproperty
    a_rx: assert property (p_rx) else $error("serial 0 receive not sampled");
endmodule : pin_mux_checker
bind shared_pin_function_select pin_mux_checker u_chk (.clk(clk), .rstn(rstn), .req(req), .periph_out(periph_out),
    .periph_in(periph_in), .p3_out(p3_out), .p3_oe(p3_oe), .p4_in(p4_in), .p4_out(p4_out), .p4_oe(p4_oe),
    .p8_out(p8_out), .p8_oe(p8_oe));
`default_nettype wire

/* File: dv/pin_far_side.sv */
/* Far side of the pins: outside sources and the two-wire pull-ups.
   Assumes the bench sets what the outside sources drive. */
`timescale 1ns/1ps
`default_nettype none
module pin_far_side (
    input wire logic [7:0] p3_out,
    input wire logic [7:0] p3_oe,
    input wire logic [7:0] p4_out,
    input wire logic [7:0] p4_oe,
    input wire logic [1:0] p9_oe,
    input wire logic [7:0] ext3,
    input wire logic [7:0] ext4,
    input wire logic [1:0] ext9,
    output logic [7:0] p3_in,
    output logic [7:0] p4_in,
    output logic [1:0] p9_in
);
    // Outside sources drive only pins the device has released
    assign p3_in = (p3_out & p3_oe) | (ext3 & ~p3_oe);
    assign p4_in = (p4_out & p4_oe) | (ext4 & ~p4_oe);
    // Pulled-up lines, low when either side pulls
    assign p9_in = ext9 & ~p9_oe;
endmodule : pin_far_side
`default_nettype wire

/* File: dv/tb_shared_pin_function_select.sv */
/* Bench for the shared pin selector: mode and enable rows, then hand cases.
   Assumes the far-side model and the bound checker. */
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin bad_count++; $display("FAIL %s exp %h got %h", nm, e, g); end end
module tb_shared_pin_function_select;
    typedef struct packed {
        logic [15:0] mode;
        logic [15:0] fe;
        logic [7:0] o3;
        logic [7:0] e3;
        logic [7:0] o4;
    } row_t;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    pin_mux_pkg::reg_req_t req = '0;
    pin_mux_pkg::periph_out_t periph_out = 22'h28FC03;
    pin_mux_pkg::periph_in_t periph_in;
    logic [15:0] rdata;
    logic [7:0] p3_in, p3_out, p3_oe, p4_in, p4_out, p4_oe, p5_out, p5_oe, p7_out, p7_oe;
    logic [7:0] ext3 = 8'h00;
    logic [7:0] ext4 = 8'h00;
    logic [1:0] ext9 = 2'h3;
    logic [1:0] p9_in, p9_out, p9_oe;
    logic p8_out, p8_oe;
    int bad_count = 0;
    int checked = 0;
    int cyc = 0;
    row_t rows [6] = '{'{16'h0, 16'h0000, 8'hAA, 8'hFF, 8'h00}, '{16'h1, 16'h001F, 8'h0D, 8'hAF, 8'h00},
        '{16'h2, 16'h001F, 8'h05, 8'hAF, 8'h00}, '{16'h2, 16'h0000, 8'hA9, 8'hFF, 8'h00},
        '{16'h0, 16'h03FF, 8'hAA, 8'hFF, 8'h76}, '{16'h1, 16'h03E0, 8'hA9, 8'hFF, 8'h76}};
    shared_pin_function_select u_dut (.clk(clk), .rstn(rstn), .req(req), .rdata(rdata), .periph_out(periph_out),
        .periph_in(periph_in), .p3_in(p3_in), .p3_out(p3_out), .p3_oe(p3_oe), .p4_in(p4_in), .p4_out(p4_out),
        .p4_oe(p4_oe), .p5_in(8'hFF), .p5_out(p5_out), .p5_oe(p5_oe), .analog_inputs(8'hFF), .p6_in(8'h00),
        .p7_in(8'h00), .p7_out(p7_out), .p7_oe(p7_oe), .p8_in(1'b0), .p8_out(p8_out), .p8_oe(p8_oe),
        .p9_in(p9_in), .p9_out(p9_out), .p9_oe(p9_oe));
    pin_far_side u_far (.p3_out(p3_out), .p3_oe(p3_oe), .p4_out(p4_out), .p4_oe(p4_oe), .p9_oe(p9_oe),
        .ext3(ext3), .ext4(ext4), .ext9(ext9), .p3_in(p3_in), .p4_in(p4_in), .p9_in(p9_in));
    always #5 clk = ~clk;
    task automatic tally_and_finish();
        if (bad_count == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : tally_and_finish
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        req <= '{a, d, 1'b1, 1'b0};
        @(posedge clk);
        req <= '0;
    endtask : wr
    task automatic rd(input logic [3:0] a, input logic [15:0] e);
        @(posedge clk);
        req <= '{a, 16'h0000, 1'b0, 1'b1};
        @(posedge clk);
        req <= '0;
        #1;
        `CHK("rdata", e, rdata)
    endtask : rd
    task automatic settle();
        repeat (3) @(posedge clk);
        #1;
    endtask : settle
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            bad_count++;
            tally_and_finish();
        end
    end
    initial begin
        repeat (3) @(posedge clk);
        #1;
        `CHK("oe_in_reset", 8'h00, p3_oe)
        @(posedge clk);
        rstn <= 1'b1;
        rd(pin_mux_pkg::REG_ANALOG_EN, 16'h00FF);
        rd(pin_mux_pkg::REG_P9_DATA, 16'h0003);
        wr(pin_mux_pkg::REG_P3_DATA, 16'h00AA);
        wr(pin_mux_pkg::REG_P3_DIR, 16'h00FF);
        wr(pin_mux_pkg::REG_P4_DIR, 16'h00FF);
        foreach (rows[i]) begin
            wr(pin_mux_pkg::REG_MODE, rows[i].mode);
            wr(pin_mux_pkg::REG_FUNC_EN, rows[i].fe);
            settle();
            `CHK("p3_oe", rows[i].e3, p3_oe)
            `CHK("p3_out", rows[i].o3, p3_out & p3_oe)
            `CHK("p4_out", rows[i].o4, p4_out)
        end
        // Mode code 3 must leave the mode alone
        wr(pin_mux_pkg::REG_MODE, 16'h0003);
        rd(pin_mux_pkg::REG_MODE, 16'h0001);
        wr(pin_mux_pkg::REG_P4_DIR, 16'h0000);
        ext4 <= 8'h89;
        settle();
        `CHK("inputs", 3'b111, {periph_in.serial0_rx_in, periph_in.serial1_rx_in, periph_in.conversion_trigger_in})
        wr(pin_mux_pkg::REG_FUNC_EN, 16'h0400);
        wr(pin_mux_pkg::REG_P8_DIR, 16'h0001);
        settle();
        `CHK("p8_out", 1'b1, p8_out & p8_oe)
        wr(pin_mux_pkg::REG_FUNC_EN, 16'h0000);
        settle();
        `CHK("p8_port", 2'b10, {p8_oe, p8_out})
        wr(pin_mux_pkg::REG_ANALOG_EN, 16'h000F);
        settle();
        rd(pin_mux_pkg::REG_P5_IN, 16'h00F0);
        `CHK("analog", 8'h0F, periph_in.analog_inputs)
        `CHK("p5_pins", 16'hF000, {p5_oe, p5_out})
        wr(pin_mux_pkg::REG_FUNC_EN, 16'h1000);
        settle();
        `CHK("p9_oe_idle", 2'h0, p9_oe)
        @(posedge clk);
        periph_out.sda_out <= 1'b0;
        settle();
        `CHK("p9_oe_low", 4'h1, {p9_out, p9_oe})
        `CHK("sda_in", 1'b0, periph_in.sda_in)
        wr(pin_mux_pkg::REG_P7_DATA, 16'h0050);
        wr(pin_mux_pkg::REG_P7_DIR, 16'h000F);
        wr(pin_mux_pkg::REG_FUNC_EN, 16'h0800);
        periph_out.compare_wave_outputs <= 8'hA5;
        settle();
        `CHK("p7_pins", 16'h0F55, {p7_oe, p7_out})
        wr(pin_mux_pkg::REG_FUNC_EN, 16'h0000);
        settle();
        `CHK("p7_port", 16'h0F50, {p7_oe, p7_out})
        tally_and_finish();
    end
endmodule : tb_shared_pin_function_select
`default_nettype wire
